// *** verilog/asp_defs.vh ***
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
// Notes on behaviour
// RL1 - Serial input is sampled on each shift clock rise while chip select is low.
// RL2 - Serial output changes only on shift clock falls, one result bit per fall.
// RL3 - Result goes out MSB first, straight binary unipolar, two's complement bipolar.
// RL4 - Serial output is released (not driven) whenever chip select is high.
// RL5 - Host lowers chip select to talk; traffic is accepted only while it is low.
// RL6 - Internal clock mode: strobe low at conversion start, high when finished.
// RL7 - External clock mode: strobe high one shift clock period before MSB decision.
// RL8 - External clock mode: strobe is released whenever chip select is high.
// RL9 - External clock mode: shift clock falls step the successive approximation.
// RL10 - Reset low returns every piece of state to the power-on default.
// RL11 - Shutdown input low stops converting and holds the converter idle.
// RL12 - Leading zeros ignored; first one starts an 8-bit control byte.
// RL13 - Control byte bits 0..2 drive user outputs; reset forces them to zero.
// RL14 - Control byte bit 5 selects internal or external conversion clocking.

// ==========================================================
// Control byte layout
`define ASP_CB_BITS     8
`define ASP_CB_BIPOLAR  6
`define ASP_CB_CLKSEL   5
`define ASP_CB_UOUT_HI  2
`define ASP_CB_UOUT_LO  0
`define ASP_UOUT_RESET  3'h0

// ==========================================================
// Conversion and timing
`define ASP_RES_WIDTH   16
`define ASP_FIFO_DEPTH  32
`define ASP_SYS_CLK_NS  10
`define ASP_INT_CLK_NS  100
`define ASP_INT_DIV     ((`ASP_INT_CLK_NS + `ASP_SYS_CLK_NS - 1) / `ASP_SYS_CLK_NS)

`endif

// *** verilog/asp_ctrl.v ***
`timescale 1ns/1ps
`include "asp_defs.vh"

// ==========================================================
// Result FIFO
module asp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem[rd_ptr_r];
    end

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // asp_fifo

// ==========================================================
// Serial port and conversion control
module asp_ctrl #(
    parameter RES_W   = `ASP_RES_WIDTH,
    parameter DEPTH   = `ASP_FIFO_DEPTH,
    parameter INT_DIV = `ASP_INT_DIV
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Serial port pins
    input  wire             cs_n,
    input  wire             sclk,
    input  wire             din,
    output reg              dout,
    output wire             dout_oe,
    output reg              conversion_strobe,
    output wire             conversion_strobe_oe,
    // Shutdown pin
    input  wire             shutdown_n,
    // User outputs
    output reg              user_output_0,
    output reg              user_output_1,
    output reg              user_output_2,
    // Converter front end
    output reg  [RES_W-1:0] dac_code,
    input  wire             cmp_above
);
    localparam [4:0] ST_IDLE    = 5'h01;
    localparam [4:0] ST_EXT_ARM = 5'h02;
    localparam [4:0] ST_EXT_STB = 5'h04;
    localparam [4:0] ST_EXT_BIT = 5'h08;
    localparam [4:0] ST_INT_BIT = 5'h10;
    localparam [3:0] MSB_IDX    = RES_W[3:0] - 4'h1;

    // Pins are brought into the clk_sys domain by two flip-flops.
    reg  [3:0]       sync1_r;
    reg  [3:0]       sync2_r;
    reg              sclk_d_r;
    wire             cs_s   = sync2_r[0];
    wire             sclk_s = sync2_r[1];
    wire             din_s  = sync2_r[2];
    wire             sd_s   = ~sync2_r[3];
    wire             rise   = sclk_s & ~sclk_d_r & ~cs_s;
    wire             fall   = ~sclk_s & sclk_d_r & ~cs_s;

    reg  [4:0]       state_r;
    reg              ext_r;
    reg              bip_r;
    reg              rx_act_r;
    reg  [6:0]       rx_sh_r;
    reg  [2:0]       rx_cnt_r;
    reg  [3:0]       idx_r;
    reg  [RES_W-1:0] res_r;
    reg  [7:0]       div_r;
    reg  [RES_W-1:0] tx_sh_r;
    reg  [4:0]       tx_cnt_r;
    reg              push_r;
    reg  [RES_W-1:0] push_data_r;

    wire [7:0]       cb      = {rx_sh_r, din_s};
    wire             cb_done = rise & rx_act_r & (rx_cnt_r == 3'h7);
    wire             tick    = (div_r == INT_DIV[7:0] - 8'h01);
    wire             fifo_in_ready;
    wire             fifo_valid;
    wire [RES_W-1:0] fifo_data;
    wire             tx_load = fall & (state_r == ST_IDLE) & (tx_cnt_r == 5'h00) & fifo_valid;
    wire             dec_bit = cmp_above;

    // Marks the result bit decided from the comparator, with the MSB inverted when bipolar.
    function out_bit;
        input [3:0] idx;
        input       b;
        input       bip;
        begin
            out_bit = (idx == MSB_IDX) ? (b ^ bip) : b; // see RL3
        end
    endfunction

    assign dout_oe              = ~cs_s;              // see RL4
    assign conversion_strobe_oe = ~(ext_r & cs_s);    // see RL8

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_r  <= 4'h9;
            sync2_r  <= 4'h9;
            sclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= {shutdown_n, din, sclk, cs_n};
            sync2_r  <= sync1_r;
            sclk_d_r <= sclk_s;
        end
    end

    // ==========================================================
    // Control byte reception, conversion and serial output
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin // see RL10
            state_r           <= ST_IDLE;
            ext_r             <= 1'b0;
            bip_r             <= 1'b0;
            rx_act_r          <= 1'b0;
            rx_sh_r           <= 7'h00;
            rx_cnt_r          <= 3'h0;
            idx_r             <= 4'h0;
            res_r             <= {RES_W{1'b0}};
            div_r             <= 8'h00;
            tx_sh_r           <= {RES_W{1'b0}};
            tx_cnt_r          <= 5'h00;
            push_r            <= 1'b0;
            push_data_r       <= {RES_W{1'b0}};
            dac_code          <= {RES_W{1'b0}};
            dout              <= 1'b0;
            conversion_strobe <= 1'b1;
            user_output_0     <= 1'b0; // see RL13
            user_output_1     <= 1'b0;
            user_output_2     <= 1'b0;
        end else begin
            push_r <= 1'b0;
            div_r  <= (tick || state_r != ST_INT_BIT) ? 8'h00 : div_r + 8'h01;
            if (cs_s) begin
                rx_act_r <= 1'b0; // see RL5
            end else if (rise) begin // see RL1
                if (!rx_act_r) begin
                    if (din_s) begin // see RL12
                        rx_act_r <= 1'b1;
                        rx_sh_r  <= 7'h01;
                        rx_cnt_r <= 3'h1;
                    end
                end else begin
                    rx_sh_r  <= cb[6:0];
                    rx_cnt_r <= rx_cnt_r + 3'h1;
                    if (cb_done) begin
                        rx_act_r <= 1'b0;
                    end
                end
            end
            case (state_r)
                ST_EXT_ARM: begin
                    if (fall) begin // see RL7
                        conversion_strobe <= 1'b1;
                        state_r           <= ST_EXT_STB;
                    end
                end
                ST_EXT_STB: begin
                    if (fall) begin
                        conversion_strobe <= 1'b0;
                        dac_code          <= {1'b1, {(RES_W-1){1'b0}}};
                        state_r           <= ST_EXT_BIT;
                    end
                end
                ST_EXT_BIT: begin
                    if (fall) begin // see RL9
                        res_r[idx_r] <= dec_bit;
                        dout         <= out_bit(idx_r, dec_bit, bip_r); // see RL2
                        dac_code     <= (res_r | (dec_bit ? ({{(RES_W-1){1'b0}}, 1'b1} << idx_r) : {RES_W{1'b0}}))
                                        | ({{(RES_W-1){1'b0}}, 1'b1} << (idx_r - 4'h1));
                        idx_r        <= idx_r - 4'h1;
                        if (idx_r == 4'h0) begin
                            state_r  <= ST_IDLE;
                            rx_act_r <= 1'b0;
                        end
                    end
                end
                ST_INT_BIT: begin
                    if (tick) begin
                        res_r[idx_r] <= dec_bit;
                        dac_code     <= (res_r | (dec_bit ? ({{(RES_W-1){1'b0}}, 1'b1} << idx_r) : {RES_W{1'b0}}))
                                        | ({{(RES_W-1){1'b0}}, 1'b1} << (idx_r - 4'h1));
                        idx_r        <= idx_r - 4'h1;
                        if (idx_r == 4'h0) begin
                            push_r            <= 1'b1;
                            push_data_r       <= {res_r[RES_W-1] ^ bip_r, res_r[RES_W-2:1], dec_bit};
                            conversion_strobe <= 1'b1; // see RL6
                            state_r           <= ST_IDLE;
                            rx_act_r          <= 1'b0;
                        end
                    end
                end
                default: begin
                    conversion_strobe <= ~ext_r;
                    if (tx_load) begin // see RL2
                        dout     <= fifo_data[RES_W-1]; // see RL3
                        tx_sh_r  <= {fifo_data[RES_W-2:0], 1'b0};
                        tx_cnt_r <= RES_W[4:0] - 5'h01;
                    end else if (fall && tx_cnt_r != 5'h00) begin
                        dout     <= tx_sh_r[RES_W-1];
                        tx_sh_r  <= {tx_sh_r[RES_W-2:0], 1'b0};
                        tx_cnt_r <= tx_cnt_r - 5'h01;
                    end
                end
            endcase
            // A new control byte aborts any conversion in progress and starts again, unless in shutdown or, for internal clocking, with the FIFO full.
            if (cb_done) begin
                user_output_0 <= cb[`ASP_CB_UOUT_LO];     // see RL13
                user_output_1 <= cb[`ASP_CB_UOUT_LO + 1];
                user_output_2 <= cb[`ASP_CB_UOUT_HI];
                bip_r         <= cb[`ASP_CB_BIPOLAR];
                ext_r         <= ~cb[`ASP_CB_CLKSEL];     // see RL14
                res_r         <= {RES_W{1'b0}};
                idx_r         <= MSB_IDX;
                if (sd_s) begin
                    state_r <= ST_IDLE;
                end else if (!cb[`ASP_CB_CLKSEL]) begin
                    conversion_strobe <= 1'b0;
                    state_r           <= ST_EXT_ARM;
                end else if (fifo_in_ready) begin
                    conversion_strobe <= 1'b0;            // see RL6
                    dac_code          <= {1'b1, {(RES_W-1){1'b0}}};
                    state_r           <= ST_INT_BIT;
                end else begin
                    state_r <= ST_IDLE;
                end
            end else if (sd_s && state_r != ST_IDLE) begin // see RL11
                state_r           <= ST_IDLE;
                conversion_strobe <= ~ext_r;
            end
        end
    end

    asp_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH),
        .AW    (5)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_r),
        .out_valid (fifo_valid),
        .out_ready (tx_load),
        .out_data  (fifo_data)
    );
endmodule // asp_ctrl

// *** dv/asp_ctrl_monitor.sv ***
`timescale 1ns/1ps
// ========================================
// Port checker
module asp_ctrl_monitor (
    input logic        clk_sys,
    input logic        rstn,
    input logic        cs_n,
    input logic        sclk,
    input logic        shutdown_n,
    input logic        dout,
    input logic        dout_oe,
    input logic        conversion_strobe,
    input logic        conversion_strobe_oe,
    input logic        user_output_0,
    input logic        user_output_1,
    input logic        user_output_2,
    input logic [15:0] dac_code
);
    wire [2:0] uo = {user_output_2, user_output_1, user_output_0};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_dout_release: assert property (cs_n [*4] |-> !dout_oe)
        else $error("dout driven while deselected");
    a_dout_drive: assert property (!cs_n [*4] |-> dout_oe)
        else $error("dout not driven while selected");
    a_dout_on_fall: assert property ($changed(dout) |-> !sclk && !$past(sclk))
        else $error("dout moved outside a shift clock fall");
    a_strobe_driven: assert property (!cs_n [*4] |-> conversion_strobe_oe)
        else $error("strobe released while selected");
    a_strobe_release: assert property
        (!conversion_strobe_oe |-> $past(cs_n, 2) || $past(cs_n, 3))
        else $error("strobe released without chip select high");
    a_user_on_rise: assert property ($changed(uo) |-> sclk && !cs_n)
        else $error("user outputs moved outside a byte");
    a_reset_defaults: assert property
        ($rose(rstn) |-> uo == 3'h0 && conversion_strobe && dac_code == 16'h0000)
        else $error("state not at default after reset");
    a_shutdown_n_hold: assert property (!shutdown_n [*8] |-> $stable(dac_code))
        else $error("converter stepping in shutdown");
endmodule // asp_ctrl_monitor

bind asp_ctrl asp_ctrl_monitor MON (.clk_sys, .rstn, .cs_n, .sclk, .shutdown_n, .dout,
    .dout_oe, .conversion_strobe, .conversion_strobe_oe, .user_output_0,
    .user_output_1, .user_output_2, .dac_code);

// *** dv/asp_host_model.sv ***
`timescale 1ns/1ps
// ========================================
// Serial host model
module asp_host_model (
    input  logic clk_sys,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input  logic dout
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    // Each call is entered at a falling edge of clk_sys.
    task automatic select(input logic v);
        cs_n = v;
        repeat (8) @(negedge clk_sys);
    endtask
    // One shift period: data with the rise, then the fall, then sample.
    task automatic clk_bit(input logic b, output logic s);
        din  = b;
        sclk = ~sclk;
        repeat (8) @(negedge clk_sys);
        sclk = ~sclk;
        repeat (8) @(negedge clk_sys);
        s = dout;
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    endtask
    task automatic read_word(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) clk_bit(1'b0, w[i]);
    endtask
endmodule // asp_host_model

// *** dv/asp_ctrl_test.sv ***
`timescale 1ns/1ps
// ========================================
// Bench top
module asp_ctrl_test;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        shutdown_n = 1'b1;
    logic [15:0] vin = 16'h0000;
    logic [15:0] w;
    logic        s;
    wire         cs_n, sclk, din, dout, dout_oe;
    wire         conversion_strobe, conversion_strobe_oe;
    wire         user_output_0, user_output_1, user_output_2;
    wire  [15:0] dac_code;
    wire         cmp_above = (vin >= dac_code);
    wire  [15:0] uo = {13'h0000, user_output_2, user_output_1, user_output_0};
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #5 clk_sys = ~clk_sys;

    asp_ctrl #(.INT_DIV(4)) DUT (.clk_sys, .rstn, .cs_n, .sclk, .din, .dout, .dout_oe,
        .conversion_strobe, .conversion_strobe_oe, .shutdown_n, .user_output_0,
        .user_output_1, .user_output_2, .dac_code, .cmp_above);
    // A released output line shows the inverse of its last bit to the host.
    asp_host_model HOST (.clk_sys, .cs_n, .sclk, .din, .dout(dout_oe ? dout : ~dout));

    task automatic check_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp,
                              input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Runs one internal conversion and reads its word back.
    task automatic int_conv(input logic [7:0] cb, input logic [15:0] v);
        vin = v;
        HOST.send_byte(cb);
        check_bit(conversion_strobe, 1'b0, "strobe converting");
        for (int i = 0; i < 300 && conversion_strobe !== 1'b1; i++) @(negedge clk_sys);
        check_bit(conversion_strobe, 1'b1, "strobe finished");
        HOST.read_word(w);
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (6) @(negedge clk_sys);
        check_bit(dout_oe, 1'b0, "dout idle");
        check_word(uo, 16'h0000, "user outputs");
        HOST.select(1'b0);
        check_bit(dout_oe, 1'b1, "dout selected");
        HOST.send_byte(8'h00);
        int_conv(8'hA5, 16'hB3C1);
        check_word(uo, 16'h0005, "user outputs");
        check_word(w, 16'hB3C1, "unipolar word");
        $display("Test internal unipolar done");
        int_conv(8'hE2, 16'h2468);
        check_word(uo, 16'h0002, "user outputs");
        check_word(w, 16'hA468, "bipolar word");
        $display("Test internal bipolar done");
        vin = 16'h5A3C;
        HOST.send_byte(8'h83);
        check_bit(conversion_strobe, 1'b1, "strobe pulse");
        HOST.clk_bit(1'b0, s);
        check_bit(conversion_strobe, 1'b0, "strobe pulse end");
        HOST.read_word(w);
        check_word(w, 16'h5A3C, "external word");
        HOST.select(1'b1);
        check_bit(conversion_strobe_oe, 1'b0, "strobe released");
        check_bit(dout_oe, 1'b0, "dout released");
        $display("Test external done");
        shutdown_n = 1'b0;
        HOST.select(1'b0);
        HOST.send_byte(8'hA7);
        check_word(uo, 16'h0007, "user outputs");
        check_bit(conversion_strobe, 1'b1, "no conversion start");
        repeat (100) @(negedge clk_sys);
        check_bit(conversion_strobe, 1'b1, "no conversion");
        $display("Test shutdown done");
        HOST.send_byte(8'h87);
        check_bit(conversion_strobe, 1'b0, "strobe external idle");
        rstn = 1'b0;
        repeat (4) @(negedge clk_sys);
        check_word(uo, 16'h0000, "user outputs");
        check_bit(conversion_strobe, 1'b1, "strobe default");
        rstn = 1'b1;
        shutdown_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        int_conv(8'hA0, 16'h8001);
        check_word(w, 16'h8001, "word after reset");
        $display("Test reset done");
        complete_run();
    end
endmodule // asp_ctrl_test
